// ### hdl/sfrb_bank1.sv
// Purpose: bank-one special-function register decode on avalon-mm
// Assumes: reset cause inputs are driven on mclk_i by the reset logic
// Notes:   every access answers on its second cycle
//
// Behaviour
// - high latch feeds counter bits twelve to eight
// - non-power resets keep unchanged fields
// - common registers answer in every bank
// - small package: port d/e direction read zero
// - unimplemented locations and bits read zero
// - unknown, unchanged, conditional reset codes honoured
`timescale 1ns/10ps
`default_nettype none

module sfrb_bank1 #(
  parameter bit FULL_PORTS = 1'b1 // 1 for the larger package
) (
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  input  wire logic                por_rst_i,
  input  wire logic                bor_rst_i,
  input  wire logic                wdt_rst_i,
  input  wire logic [10:0]         address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [3:0]          byteenable,
  input  wire logic [31:0]         writedata,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  input  wire logic [1:0]          psp_full_i,
  input  wire logic                psp_ovf_i,
  input  wire logic                tx_empty_i,
  input  wire logic [7:0]          ind_rdata_i,
  output sfrb_pkg::sfrb_ind_t      ind_o,
  output sfrb_pkg::sfrb_regs_t     cfg_o,
  output logic [12:0]              pc_o,
  output logic                     pc_load_o,
  output logic                     irq_o
);
  import sfrb_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  sfrb_regs_t  r;          // register contents
  sfrb_regs_t  next_r;
  logic        ack;        // second cycle of an access
  logic        next_ack;
  logic [31:0] next_readdata;
  logic [12:0] next_pc_o;
  logic        next_pc_load_o;
  logic [7:0]  wbuf;       // write data held for the indirect port
  logic [7:0]  next_wbuf;
  logic [EV_W-1:0] ev;     // sticky event status
  logic [EV_W-1:0] next_ev;
  logic [EV_W-1:0] evm;    // event mask
  logic [EV_W-1:0] next_evm;
  logic        ind_rd;
  logic        next_ind_rd;
  logic        ind_wr;
  logic        next_ind_wr;
  logic        pwr_q;      // power-up reset held last cycle, for checks
  logic        wdt_q;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [8:0] idx;     // register index from byte address
  logic       common;  // offset mirrored in all banks
  logic [8:0] sel;     // index folded onto bank one
  logic       hit;     // implemented location
  logic       small_gap;
  logic       req;
  logic       wr_ok;
  logic       rd_done;
  logic       pwr;
  logic [7:0] wd;
  logic [7:0] rd_val;

  assign idx = address[10:2];
  assign req = read | write;
  assign wd  = writedata[7:0];
  assign pwr = por_rst_i | bor_rst_i;

  // fold common offsets onto bank one
  always_comb begin
    case (idx[6:0])
      7'h00, 7'h02, 7'h03, 7'h04, 7'h0a, 7'h0b: common = 1'b1;
      default:                                   common = 1'b0;
    endcase
    sel = common ? {2'b01, idx[6:0]} : idx;
  end

  // small package drops port d/e direction
  assign small_gap = !FULL_PORTS && (sel == IX_PORT_D_DIRECTION || sel == IX_PORT_E_DIRECTION_SLAVE_STATUS);

  // read mux; anything not listed reads zero
  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    case (sel)
      IX_INDIRECT_ACCESS_PORT:   rd_val = (ind_o.addr == 9'h000) ? 8'h00 : ind_rdata_i;
      IX_OPTION: rd_val = r.option;
      IX_PCL:    rd_val = pc_o[7:0];
      IX_STATUS: rd_val = r.status;
      IX_FSR:    rd_val = r.indirect_address_pointer;
      IX_PORT_A_DIRECTION:  rd_val = r.tris_a & WM_PORT_A_DIRECTION;
      IX_PORT_B_DIRECTION:  rd_val = r.tris_b;
      IX_PORT_C_DIRECTION:  rd_val = r.tris_c;
      IX_PORT_D_DIRECTION:  rd_val = r.tris_d;
      IX_PORT_E_DIRECTION_SLAVE_STATUS:  rd_val = r.tris_e;
      IX_PROGRAM_COUNTER_HIGH_LATCH: rd_val = {3'h0, r.program_counter_high_latch};
      IX_INTERRUPT_CONTROL: rd_val = r.interrupt_control;
      IX_PERIPHERAL_IRQ_ENABLE_ONE:   rd_val = r.peripheral_irq_enable_one & WM_PERIPHERAL_IRQ_ENABLE_ONE;
      IX_PERIPHERAL_IRQ_ENABLE_TWO:   rd_val = r.peripheral_irq_enable_two & WM_PERIPHERAL_IRQ_ENABLE_TWO;
      IX_RESET_CAUSE_FLAGS:   rd_val = {6'h00, r.reset_cause_flags};
      IX_PR2:    rd_val = r.pr2;
      IX_SERIAL_TRANSMIT_CONTROL:  rd_val = r.serial_transmit_control;
      IX_BAUD_RATE_DIVISOR:  rd_val = r.baud_rate_divisor;
      IX_CONVERTER_CONFIGURATION: rd_val = r.converter_configuration & WM_CONVERTER_CONFIGURATION;
      IX_EVSTAT: rd_val = {5'h00, ev};
      IX_EVMASK: rd_val = {5'h00, evm};
      default:   hit    = 1'b0;
    endcase
    if (small_gap) begin
      hit    = 1'b0;
      rd_val = 8'h00;
    end
  end

  // ****************************************************************
  // bus handshake: first cycle waits, second cycle answers
  // ****************************************************************
  assign waitrequest = req & ~ack;
  assign wr_ok       = write & ack & byteenable[0];
  assign rd_done     = read & ack;

  // ****************************************************************
  // next register values
  // ****************************************************************
  always_comb begin
    next_r         = r;
    next_ack       = req & ~ack;
    next_readdata  = readdata;
    next_pc_o      = pc_o;
    next_pc_load_o = 1'b0;
    next_wbuf      = wbuf;
    next_ev        = ev;
    next_evm       = evm;
    next_ind_rd    = 1'b0;
    next_ind_wr    = 1'b0;
    // first cycle: capture the answer and the write byte
    if (req && !ack) begin
      next_readdata = {24'h000000, read ? rd_val : 8'h00};
      next_wbuf     = wd;
      next_ind_rd   = read && sel == IX_INDIRECT_ACCESS_PORT;
    end
    // reading the event status clears it; new events still land below
    if (rd_done && sel == IX_EVSTAT)
      next_ev = RV_EV;
    if (wr_ok && hit) begin
      case (sel)
        IX_INDIRECT_ACCESS_PORT:   next_ind_wr = 1'b1;
        IX_OPTION: next_r.option = wd;
        IX_PCL: begin
          // loading the counter takes the latch as the top
          next_pc_o      = {r.program_counter_high_latch, wd};
          next_pc_load_o = 1'b1;
        end
        IX_STATUS:
          next_r.status = (r.status & ~WM_STATUS) | (wd & WM_STATUS);
        IX_FSR:    next_r.indirect_address_pointer    = wd;
        IX_PORT_A_DIRECTION:  next_r.tris_a = wd & WM_PORT_A_DIRECTION;
        IX_PORT_B_DIRECTION:  next_r.tris_b = wd;
        IX_PORT_C_DIRECTION:  next_r.tris_c = wd;
        IX_PORT_D_DIRECTION:  next_r.tris_d = wd;
        IX_PORT_E_DIRECTION_SLAVE_STATUS:
          next_r.tris_e = (r.tris_e & ~WM_PORT_E_DIRECTION_SLAVE_STATUS) | (wd & WM_PORT_E_DIRECTION_SLAVE_STATUS);
        IX_PROGRAM_COUNTER_HIGH_LATCH: next_r.program_counter_high_latch = wd[4:0];
        IX_INTERRUPT_CONTROL: next_r.interrupt_control = wd;
        // bit seven stored as written; clearing it on the small
        // package is software's job
        IX_PERIPHERAL_IRQ_ENABLE_ONE:   next_r.peripheral_irq_enable_one   = wd & WM_PERIPHERAL_IRQ_ENABLE_ONE;
        IX_PERIPHERAL_IRQ_ENABLE_TWO:   next_r.peripheral_irq_enable_two   = wd & WM_PERIPHERAL_IRQ_ENABLE_TWO;
        IX_RESET_CAUSE_FLAGS:   next_r.reset_cause_flags   = wd[1:0];
        IX_PR2:    next_r.pr2    = wd;
        IX_SERIAL_TRANSMIT_CONTROL:
          next_r.serial_transmit_control = (r.serial_transmit_control & ~WM_SERIAL_TRANSMIT_CONTROL) | (wd & WM_SERIAL_TRANSMIT_CONTROL);
        IX_BAUD_RATE_DIVISOR:  next_r.baud_rate_divisor  = wd;
        IX_CONVERTER_CONFIGURATION: next_r.converter_configuration = wd & WM_CONVERTER_CONFIGURATION;
        IX_EVMASK: next_evm      = wd[EV_W-1:0];
        default:   next_r = r;
      endcase
    end
    // live status bits from the peripherals; overflow set wins clear
    next_r.tris_e[TE_IBF]  = FULL_PORTS & psp_full_i[1];
    next_r.tris_e[TE_OBF]  = FULL_PORTS & psp_full_i[0];
    if (FULL_PORTS && psp_ovf_i)
      next_r.tris_e[TE_IBOV] = 1'b1;
    next_r.serial_transmit_control[TX_TRMT]  = tx_empty_i;
    // events are sticky; set wins over the read clear
    if (wr_ok && hit && sel == IX_PCL)
      next_ev[EV_PCLD] = 1'b1;
    if (ack && req && hit && sel == IX_INDIRECT_ACCESS_PORT)
      next_ev[EV_IND] = 1'b1;
    if (ack && req && !hit)
      next_ev[EV_UNM] = 1'b1;
    // ************ reset ************
    if (srst_i) begin
      next_ack       = 1'b0;
      next_readdata  = 32'h00000000;
      next_pc_o      = 13'h0000;
      next_pc_load_o = 1'b0;
      next_ind_rd    = 1'b0;
      next_ind_wr    = 1'b0;
      next_ev        = RV_EV;
      next_evm       = RV_EV;
      // fields common to both reset columns
      next_r.option = RV_OPTION;
      next_r.tris_a = RV_PORT_A_DIRECTION;
      next_r.tris_b = RV_TRISBD;
      next_r.tris_c = RV_TRISBD;
      next_r.tris_d = RV_TRISBD;
      next_r.tris_e = RV_PORT_E_DIRECTION_SLAVE_STATUS;
      next_r.program_counter_high_latch = RV_PROGRAM_COUNTER_HIGH_LATCH;
      next_r.peripheral_irq_enable_one   = RV_PIE;
      next_r.peripheral_irq_enable_two   = RV_PIE;
      next_r.pr2    = RV_PR2;
      next_r.serial_transmit_control  = RV_SERIAL_TRANSMIT_CONTROL;
      next_r.baud_rate_divisor  = RV_BAUD_RATE_DIVISOR;
      next_r.converter_configuration = RV_CONVERTER_CONFIGURATION;
      next_r.interrupt_control = {RV_INTERRUPT_CONTROL[7:1], r.interrupt_control[IC_RBIF]};
      if (pwr) begin
        // power-up: unknown bits start at zero
        next_r.status = RV_STATUS;
        next_r.indirect_address_pointer    = RV_FSR;
        next_r.interrupt_control = RV_INTERRUPT_CONTROL;
        next_r.reset_cause_flags   = {~por_rst_i, ~bor_rst_i};
      end else begin
        // pin or watchdog: keep u fields
        next_r.status[7:5] = RV_STATUS[7:5];
        // time-out bit is conditional on the cause
        if (wdt_rst_i)
          next_r.status[ST_TO] = 1'b0;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    r         <= next_r;
    ack       <= next_ack;
    readdata  <= next_readdata;
    pc_o      <= next_pc_o;
    pc_load_o <= next_pc_load_o;
    wbuf      <= next_wbuf;
    ev        <= next_ev;
    evm       <= next_evm;
    ind_rd    <= next_ind_rd;
    ind_wr    <= next_ind_wr;
    pwr_q     <= srst_i & pwr;
    wdt_q     <= srst_i & ~pwr & wdt_rst_i;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // irp plus pointer: a nine-bit data address for indirect access
  assign ind_o = '{addr: {r.status[ST_IRP], r.indirect_address_pointer}, rd: ind_rd,
                   wr: ind_wr, wdata: wbuf};
  assign cfg_o = r;
  assign irq_o = |(ev & evm);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_first;
    req && !ack;
  endsequence
  sequence s_answer;
    !waitrequest;
  endsequence

  chk_bus_answer: assert property (
    s_first |-> waitrequest ##1 s_answer)
    else $error("access not answered on second cycle");
  chk_pc_upper: assert property (
    wr_ok && sel == IX_PCL |=>
      pc_load_o && pc_o == {$past(r.program_counter_high_latch), $past(wd)})
    else $error("counter top not taken from high latch");
  chk_common_fsr: assert property (
    wr_ok && idx == 9'h104 |=> r.indirect_address_pointer == $past(wd))
    else $error("pointer not reached from bank two");
  chk_small_zero: assert property (
    rd_done && !FULL_PORTS && (sel == IX_PORT_D_DIRECTION || sel == IX_PORT_E_DIRECTION_SLAVE_STATUS)
      |-> readdata == 32'h00000000)
    else $error("small package direction read not zero");
  chk_unmapped_zero: assert property (
    rd_done && !hit |-> readdata == 32'h00000000 ##1 ev[EV_UNM])
    else $error("unmapped read not zero or not flagged");
  // must run while reset is high, so the default disable is overridden
  chk_other_keep: assert property (
    disable iff (1'b0) srst_i && !pwr |=> r.indirect_address_pointer == $past(r.indirect_address_pointer))
    else $error("pointer changed by non-power reset");
  chk_wdt_timeout: assert property (
    $past(wdt_q) && !$past(pwr_q) |-> !r.status[ST_TO])
    else $error("time-out bit not cleared by watchdog");
  chk_por_values: assert property (
    $past(pwr_q) |-> r.option == RV_OPTION && r.peripheral_irq_enable_one == RV_PIE &&
      r.tris_a == RV_PORT_A_DIRECTION && r.status == RV_STATUS)
    else $error("power-on values not loaded");
  // a counter load is an event: sticky bit set, level if unmasked
  chk_irq_level: assert property (
    wr_ok && hit && sel == IX_PCL |=>
      ev[EV_PCLD] && (irq_o || !evm[EV_PCLD]))
    else $error("interrupt not raised with unmasked event");

endmodule

`default_nettype wire

// ### inc/sfrb_pkg.sv
// Purpose: constants and types for the bank-one special-function registers
// Assumes: byte address on the bus is four times the register index
// Notes:   indexes are nine bits: two bank bits over a seven-bit offset
package sfrb_pkg;

  // ****************************************************************
  // register indexes
  // ****************************************************************
  localparam logic [8:0] IX_INDIRECT_ACCESS_PORT   = 9'h080; // indirect access port
  localparam logic [8:0] IX_OPTION = 9'h081; // timer and pull-up options
  localparam logic [8:0] IX_PCL    = 9'h082; // program counter low
  localparam logic [8:0] IX_STATUS = 9'h083; // core status flags
  localparam logic [8:0] IX_FSR    = 9'h084; // indirect address pointer
  localparam logic [8:0] IX_PORT_A_DIRECTION  = 9'h085; // port a direction
  localparam logic [8:0] IX_PORT_B_DIRECTION  = 9'h086; // port b direction
  localparam logic [8:0] IX_PORT_C_DIRECTION  = 9'h087; // port c direction
  localparam logic [8:0] IX_PORT_D_DIRECTION  = 9'h088; // port d direction
  localparam logic [8:0] IX_PORT_E_DIRECTION_SLAVE_STATUS  = 9'h089; // port e direction, slave status
  localparam logic [8:0] IX_PROGRAM_COUNTER_HIGH_LATCH = 9'h08a; // program counter high latch
  localparam logic [8:0] IX_INTERRUPT_CONTROL = 9'h08b; // interrupt control
  localparam logic [8:0] IX_PERIPHERAL_IRQ_ENABLE_ONE   = 9'h08c; // peripheral enables one
  localparam logic [8:0] IX_PERIPHERAL_IRQ_ENABLE_TWO   = 9'h08d; // peripheral enables two
  localparam logic [8:0] IX_RESET_CAUSE_FLAGS   = 9'h08e; // reset cause flags
  localparam logic [8:0] IX_PR2    = 9'h092; // timer2 period
  localparam logic [8:0] IX_SERIAL_TRANSMIT_CONTROL  = 9'h098; // serial transmit control
  localparam logic [8:0] IX_BAUD_RATE_DIVISOR  = 9'h099; // baud rate divisor
  localparam logic [8:0] IX_CONVERTER_CONFIGURATION = 9'h09f; // converter configuration
  localparam logic [8:0] IX_EVSTAT = 9'h1f8; // block event status
  localparam logic [8:0] IX_EVMASK = 9'h1f9; // block event mask

  // ****************************************************************
  // power-on values, unknown bits taken as zero
  // ****************************************************************
  localparam logic [7:0] RV_OPTION = 8'hff;
  localparam logic [7:0] RV_PCL    = 8'h00;
  localparam logic [7:0] RV_STATUS = 8'h18;
  localparam logic [7:0] RV_FSR    = 8'h00;
  localparam logic [7:0] RV_PORT_A_DIRECTION  = 8'h3f;
  localparam logic [7:0] RV_TRISBD = 8'hff;
  localparam logic [7:0] RV_PORT_E_DIRECTION_SLAVE_STATUS  = 8'h07;
  localparam logic [4:0] RV_PROGRAM_COUNTER_HIGH_LATCH = 5'h00;
  localparam logic [7:0] RV_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RV_PIE    = 8'h00;
  localparam logic [7:0] RV_PR2    = 8'hff;
  localparam logic [7:0] RV_SERIAL_TRANSMIT_CONTROL  = 8'h02;
  localparam logic [7:0] RV_BAUD_RATE_DIVISOR  = 8'h00;
  localparam logic [7:0] RV_CONVERTER_CONFIGURATION = 8'h00;
  localparam logic [2:0] RV_EV     = 3'h0;

  // ****************************************************************
  // writable bit masks and field positions
  // ****************************************************************
  localparam logic [7:0] WM_STATUS = 8'he7; // time-out, power-down read only
  localparam logic [7:0] WM_PORT_A_DIRECTION  = 8'h3f;
  localparam logic [7:0] WM_PORT_E_DIRECTION_SLAVE_STATUS  = 8'h37;
  localparam logic [7:0] WM_PERIPHERAL_IRQ_ENABLE_ONE   = 8'hf7;
  localparam logic [7:0] WM_PERIPHERAL_IRQ_ENABLE_TWO   = 8'h10;
  localparam logic [7:0] WM_SERIAL_TRANSMIT_CONTROL  = 8'hf5;
  localparam logic [7:0] WM_CONVERTER_CONFIGURATION = 8'h8f;
  localparam int ST_IRP  = 7; // status: indirect bank select
  localparam int ST_TO   = 4; // status: time-out, low after watchdog
  localparam int ST_PD   = 3; // status: power-down
  localparam int TE_IBF  = 7; // slave port input full
  localparam int TE_OBF  = 6; // slave port output full
  localparam int TE_IBOV = 5; // slave port overflow
  localparam int TX_TRMT = 1; // transmit shifter empty
  localparam int IC_RBIF = 0; // port b change flag
  localparam int EV_PCLD = 0; // event: program counter loaded
  localparam int EV_IND  = 1; // event: indirect access
  localparam int EV_UNM  = 2; // event: unmapped access
  localparam int EV_W    = 3;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] option;
    logic [7:0] status;
    logic [7:0] indirect_address_pointer;
    logic [7:0] tris_a;
    logic [7:0] tris_b;
    logic [7:0] tris_c;
    logic [7:0] tris_d;
    logic [7:0] tris_e;
    logic [4:0] program_counter_high_latch;
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_enable_one;
    logic [7:0] peripheral_irq_enable_two;
    logic [1:0] reset_cause_flags;
    logic [7:0] pr2;
    logic [7:0] serial_transmit_control;
    logic [7:0] baud_rate_divisor;
    logic [7:0] converter_configuration;
  } sfrb_regs_t;

  typedef struct packed {
    logic [8:0] addr;  // irp and pointer
    logic       rd;    // read pulse
    logic       wr;    // write pulse
    logic [7:0] wdata; // write data
  } sfrb_ind_t;

endpackage

// ### verif/sfrb_bank1_tb_top.sv
// Purpose: self-checking bench for the bank-one register decode
// Assumes: every access answers in two cycles on both instances
// Notes:   a second instance stands for the smaller package
`timescale 1ns/10ps
`default_nettype none

module sfrb_bank1_tb_top;
  import sfrb_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        mclk_i;      // 25 MHz core clock
  logic        srst_i;      // synchronous reset
  logic        por_rst_i;   // power-on cause
  logic        bor_rst_i;   // brown-out cause
  logic        wdt_rst_i;   // watchdog cause
  logic [10:0] address;     // byte address
  logic        read;        // read request
  logic        write;       // write request
  logic [3:0]  byteenable;  // lane 0 only
  logic [31:0] writedata;   // write byte in lane 0
  logic [31:0] readdata;    // large package answer
  logic [31:0] readdata_s;  // small package answer
  logic        waitrequest; // large package stall
  logic        wait_s;      // small package stall, unused
  logic [1:0]  psp_full_i;  // slave port full levels
  logic        psp_ovf_i;   // slave port overflow pulse
  logic        tx_empty_i;  // transmit shifter empty
  logic [7:0]  ind_rdata_i; // indirect read data
  sfrb_ind_t   ind_o;       // indirect access request
  logic [12:0] pc_o;        // program counter
  logic        pc_load_o;   // counter load pulse
  logic        irq_o;       // interrupt level
  int          err_total;   // mismatches
  int          comparisons; // checks made
  int          cycles;      // hang guard
  int          loads;       // counter load pulses seen
  logic [7:0]  rd;          // last byte read, large package
  logic [7:0]  rd_s;        // same access, small package

  // power-on table, unknown bits taken as zero
  localparam logic [8:0] POR_IX [19] = '{IX_INDIRECT_ACCESS_PORT, IX_OPTION, IX_PCL,
    IX_STATUS, IX_FSR, IX_PORT_A_DIRECTION, IX_PORT_B_DIRECTION, IX_PORT_C_DIRECTION, IX_PORT_D_DIRECTION, IX_PORT_E_DIRECTION_SLAVE_STATUS,
    IX_PROGRAM_COUNTER_HIGH_LATCH, IX_INTERRUPT_CONTROL, IX_PERIPHERAL_IRQ_ENABLE_ONE, IX_PERIPHERAL_IRQ_ENABLE_TWO, IX_RESET_CAUSE_FLAGS, IX_PR2, IX_SERIAL_TRANSMIT_CONTROL,
    IX_BAUD_RATE_DIVISOR, IX_CONVERTER_CONFIGURATION};
  localparam logic [7:0] POR_EV [19] = '{8'h00, 8'hff, 8'h00, 8'h18, 8'h00,
    8'h3f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'hff, 8'h02, 8'h00, 8'h00};
  // write then read back: unimplemented bits must come back zero
  localparam logic [8:0] WR_IX [12] = '{IX_PORT_A_DIRECTION, IX_PORT_E_DIRECTION_SLAVE_STATUS, IX_PROGRAM_COUNTER_HIGH_LATCH,
    IX_PERIPHERAL_IRQ_ENABLE_ONE, IX_PERIPHERAL_IRQ_ENABLE_TWO, IX_SERIAL_TRANSMIT_CONTROL, IX_CONVERTER_CONFIGURATION, IX_OPTION, IX_PR2, IX_BAUD_RATE_DIVISOR,
    IX_PORT_B_DIRECTION, 9'h08f};
  localparam logic [7:0] WR_D [12] = '{8'hff, 8'h17, 8'hff, 8'h7f, 8'hff,
    8'hff, 8'hff, 8'h5a, 8'h00, 8'h3c, 8'h00, 8'hff};
  localparam logic [7:0] WR_EV [12] = '{8'h3f, 8'h17, 8'h1f, 8'h77, 8'h10,
    8'hf7, 8'h8f, 8'h5a, 8'h00, 8'h3c, 8'h00, 8'h00};

  // ****************************************************************
  // devices: large and small package side by side on one bus
  // ****************************************************************
  sfrb_bank1 #(.FULL_PORTS(1'b1)) u_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .por_rst_i(por_rst_i),
    .bor_rst_i(bor_rst_i), .wdt_rst_i(wdt_rst_i), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .psp_full_i(psp_full_i), .psp_ovf_i(psp_ovf_i), .tx_empty_i(tx_empty_i),
    .ind_rdata_i(ind_rdata_i), .ind_o(ind_o), .cfg_o(), .pc_o(pc_o),
    .pc_load_o(pc_load_o), .irq_o(irq_o));
  sfrb_bank1 #(.FULL_PORTS(1'b0)) u_dut_small (
    .mclk_i(mclk_i), .srst_i(srst_i), .por_rst_i(por_rst_i),
    .bor_rst_i(bor_rst_i), .wdt_rst_i(wdt_rst_i), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata_s), .waitrequest(wait_s),
    .psp_full_i(psp_full_i), .psp_ovf_i(psp_ovf_i), .tx_empty_i(tx_empty_i),
    .ind_rdata_i(ind_rdata_i), .ind_o(), .cfg_o(), .pc_o(),
    .pc_load_o(), .irq_o());

  // ****************************************************************
  // clock, hang guard and load pulse counter
  // ****************************************************************
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // whole run is well under a thousand cycles; four times that is a hang
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (pc_load_o === 1'b1) loads = loads + 1;
    if (cycles == 4000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [12:0] exp,
                     input logic [12:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [8:0] ix,
                        input logic [7:0] wd);
    address   <= {ix, 2'b00};
    writedata <= {24'h000000, wd};
    read      <= ~wr;
    write     <= wr;
    // no local limit: only the hang guard may end a stalled access
    do begin
      @(posedge mclk_i);
    end while (waitrequest !== 1'b0);
    rd   = readdata[7:0];
    rd_s = readdata_s[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    // idle edge keeps two drives of one strobe out of one time step
    @(posedge mclk_i);
  endtask

  task automatic rdchk(input logic [8:0] ix, input logic [7:0] exp);
    access(1'b0, ix, 8'h00);
    chk($sformatf("register %h", ix), {5'h00, exp}, {5'h00, rd});
  endtask

  task automatic reset_dut(input logic por, input logic bor, input logic wdt);
    srst_i    <= 1'b1;
    por_rst_i <= por;
    bor_rst_i <= bor;
    wdt_rst_i <= wdt;
    repeat (6) @(posedge mclk_i);
    srst_i    <= 1'b0;
    por_rst_i <= 1'b0;
    bor_rst_i <= 1'b0;
    wdt_rst_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    loads = 0;
    srst_i = 1'b1;
    por_rst_i = 1'b1;
    bor_rst_i = 1'b0;
    wdt_rst_i = 1'b0;
    address = 11'h000;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h1;
    writedata = 32'h00000000;
    psp_full_i = 2'h0;
    psp_ovf_i = 1'b0;
    tx_empty_i = 1'b1;
    ind_rdata_i = 8'ha5;
    reset_dut(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 19; i++) rdchk(POR_IX[i], POR_EV[i]);
    // small package: port d direction absent, same access on both
    rdchk(IX_PORT_D_DIRECTION, 8'hff);
    chk("small port d", 13'h000, {5'h00, rd_s});
    for (int i = 0; i < 12; i++) begin
      access(1'b1, WR_IX[i], WR_D[i]);
      rdchk(WR_IX[i], WR_EV[i]);
    end
    // slave port status bits in port e direction
    psp_full_i <= 2'h2;
    psp_ovf_i <= 1'b1;
    @(posedge mclk_i);
    psp_ovf_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rdchk(IX_PORT_E_DIRECTION_SLAVE_STATUS, 8'hb7);
    chk("small port e", 13'h000, {5'h00, rd_s});
    access(1'b1, IX_PORT_E_DIRECTION_SLAVE_STATUS, 8'h17);
    rdchk(IX_PORT_E_DIRECTION_SLAVE_STATUS, 8'h97);
    // common registers reached from other banks
    access(1'b1, 9'h00a, 8'h15);
    rdchk(9'h18a, 8'h15);
    access(1'b1, 9'h104, 8'h20);
    rdchk(IX_FSR, 8'h20);
    rdchk(9'h000, 8'ha5);
    chk("indirect addr", 13'h0020, {4'h0, ind_o.addr});
    // counter load takes the high latch as bits twelve to eight
    access(1'b1, 9'h182, 8'h3c);
    repeat (2) @(posedge mclk_i);
    chk("pc value", 13'h153c, pc_o);
    chk("pc loads", 13'h0001, loads[12:0]);
    rdchk(IX_PCL, 8'h3c);
    // event interrupt: raise, clear by read, then masked
    access(1'b0, IX_EVSTAT, 8'h00);
    access(1'b1, IX_EVMASK, 8'h04);
    rdchk(9'h090, 8'h00);
    chk("irq raised", 13'h0001, {12'h000, irq_o});
    rdchk(IX_EVSTAT, 8'h04);
    chk("irq cleared", 13'h0000, {12'h000, irq_o});
    access(1'b1, IX_EVMASK, 8'h00);
    access(1'b0, 9'h08f, 8'h00);
    chk("irq masked", 13'h0000, {12'h000, irq_o});
    rdchk(IX_EVSTAT, 8'h04);
    // pin reset then watchdog reset keep the unchanged fields
    access(1'b1, IX_STATUS, 8'h07);
    access(1'b1, IX_INTERRUPT_CONTROL, 8'hff);
    rdchk(IX_STATUS, 8'h1f);
    reset_dut(1'b0, 1'b0, 1'b0);
    rdchk(IX_STATUS, 8'h1f);
    rdchk(IX_FSR, 8'h20);
    rdchk(IX_INTERRUPT_CONTROL, 8'h01);
    rdchk(IX_OPTION, 8'hff);
    rdchk(IX_PROGRAM_COUNTER_HIGH_LATCH, 8'h00);
    rdchk(IX_RESET_CAUSE_FLAGS, 8'h01);
    reset_dut(1'b0, 1'b0, 1'b1);
    rdchk(IX_STATUS, 8'h0f);
    // brown-out is a power-up event
    reset_dut(1'b0, 1'b1, 1'b0);
    rdchk(IX_RESET_CAUSE_FLAGS, 8'h02);
    rdchk(IX_STATUS, 8'h18);
    rdchk(IX_FSR, 8'h00);
    finish_test();
  end

endmodule

`default_nettype wire
